/* hw/dstr_pkg.sv */
package dstr_pkg;
    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_FRAME_COUNT_LOW = 8'h67;
    localparam logic [7:0] OFS_FRAME_COUNT_MID = 8'h68;
    localparam logic [7:0] OFS_FRAME_COUNT_HIGH = 8'h69;
    localparam logic [7:0] OFS_MEAN_STREAM_RATE = 8'h6A;
    localparam logic [7:0] OFS_FIRMWARE_VERSION = 8'h71;
    localparam logic [7:0] OFS_RUN = 8'h72;
    localparam logic [7:0] OFS_HIGH_CORNER_LO = 8'h77;
    localparam logic [7:0] OFS_HIGH_CORNER_HI = 8'h78;
    localparam logic [7:0] OFS_LOW_CORNER_LO = 8'h79;
    localparam logic [7:0] OFS_LOW_CORNER_HI = 8'h7A;
    localparam logic [7:0] OFS_HIGH_SHELF_GAIN = 8'h7B;
    localparam logic [7:0] OFS_LOW_SHELF_GAIN = 8'h7C;
    localparam logic [7:0] OFS_TONE_HEADROOM = 8'h7D;

    // ========================================================
    // widths, fields and reset values
    localparam int REG_W = 8;
    localparam int FRAME_CNT_W = 24;
    localparam int CORNER_W = 16;
    localparam int RATE_IN_W = 9;
    localparam int RUN_BIT = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [15:0] RST_CORNER = 16'h0000;
    localparam logic [23:0] RST_FRAME_CNT = 24'h000000;
    localparam logic [23:0] FRAME_CNT_ONE = 24'h000001;
    localparam logic [8:0] RATE_ROUND = 9'h001;

    // ========================================================
    // gain limits: 12 steps of 1.5 dB make 18 dB
    localparam logic signed [7:0] GAIN_MAX_STEPS = 8'sh0C;
    localparam logic signed [7:0] GAIN_MIN_STEPS = -8'sh0C;

    // ========================================================
    // decoder run state
    typedef enum logic [1:0] {
        DSTR_IDLE = 2'b01,
        DSTR_DECODE = 2'b10
    } dstr_run_state_t;
endpackage : dstr_pkg

/* hw/dstr_sample_latch.sv */
`timescale 1ns/100ps
// ============================================================
// shadow copy that follows its source only on an audio sample
module dstr_sample_latch #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic sample_tick,
    input wire logic [WIDTH-1:0] src,
    output logic [WIDTH-1:0] applied
);
    // ========================================================
    // update on sample boundary so a sample never sees half a change
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            applied <= '0;
        end else if (sample_tick) begin
            applied <= src;
        end
    end
endmodule : dstr_sample_latch

/* hw/decoder_status_tone_regs.sv */
`timescale 1ns/100ps
// Summary of operation
// (R1) 24-bit frame count over three byte registers
// (R2) count advances once per decoded frame
// (R3) both resets clear the frame count
// (R4) mean stream rate halved, whole kbit/s
// (R5) firmware version readable after boot
// (R6) run bit starts decoding, resets clear
// (R7) host sets run after full setup
// (R8) treble corner is 16-bit, high byte above
// (R9) host keeps treble corner below Fs/2
// (R10) bass corner is 16-bit hertz value
// (R11) host keeps bass corner within limits
// (R12) treble gain signed, 1.5 dB, +-18 dB
// (R13) bass gain signed, 1.5 dB, +-18 dB
// (R14) headroom attenuates 1.5 dB per unit
// (R15) host sets headroom at least the boost
// (R16) read-only writes ignored; settings per sample
module decoder_status_tone_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [dstr_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [dstr_pkg::REG_W-1:0] reg_rdata,
    input wire logic frame_done,
    input wire logic [dstr_pkg::RATE_IN_W-1:0] avg_rate_kbps,
    input wire logic boot_done,
    input wire logic [dstr_pkg::REG_W-1:0] fw_version_code,
    input wire logic sample_tick,
    output logic decode_run,
    output logic [dstr_pkg::CORNER_W-1:0] treble_corner_hz,
    output logic [dstr_pkg::CORNER_W-1:0] bass_corner_hz,
    output logic signed [dstr_pkg::REG_W-1:0] treble_gain_steps,
    output logic signed [dstr_pkg::REG_W-1:0] bass_gain_steps,
    output logic [dstr_pkg::REG_W-1:0] headroom_steps,
    output logic [dstr_pkg::FRAME_CNT_W-1:0] frame_count
);
    import dstr_pkg::*;

    // ========================================================
    // storage
    logic clr_all;
    logic [FRAME_CNT_W-1:0] frame_cnt_ff;
    logic [REG_W-1:0] rate_ff;
    logic [REG_W-1:0] fw_ver_ff;
    logic run_ff;
    logic [CORNER_W-1:0] high_corner_ff;
    logic [CORNER_W-1:0] low_corner_ff;
    logic [REG_W-1:0] high_gain_ff;
    logic [REG_W-1:0] low_gain_ff;
    logic [REG_W-1:0] headroom_ff;
    logic [REG_W-1:0] rdata_ff;
    logic [REG_W-1:0] nxt_rdata;
    logic [FRAME_CNT_W-1:0] nxt_frame_cnt;
    logic [RATE_IN_W-1:0] rate_rounded;
    logic [RATE_IN_W:0] rate_sum;
    logic signed [REG_W-1:0] high_gain_lim;
    logic signed [REG_W-1:0] low_gain_lim;
    logic run_applied;
    logic [REG_W-1:0] high_gain_applied;
    logic [REG_W-1:0] low_gain_applied;
    dstr_run_state_t state_ff;
    dstr_run_state_t nxt_state;

    // hardware and software reset act alike on every register here except firmware version and read data, which only the hardware reset clears
    assign clr_all = rst || sw_reset;

    // ========================================================
    // frame counter
    // (R2) count decoded frames
    assign nxt_frame_cnt = frame_cnt_ff + FRAME_CNT_ONE;

    // (R3) clear on either reset
    always_ff @(posedge clk) begin
        if (clr_all) begin
            frame_cnt_ff <= RST_FRAME_CNT;
        end else if (frame_done) begin
            frame_cnt_ff <= nxt_frame_cnt;
        end
    end

    // ========================================================
    // mean stream rate, refreshed once per decoded frame
    // (R4) halve with rounding to whole kbit/s
    // one spare bit holds the rounding carry, but only the low byte is stored, so a top-of-range rate of 511 reads as zero
    assign rate_sum = {1'b0, avg_rate_kbps} + {1'b0, RATE_ROUND};
    assign rate_rounded = rate_sum[RATE_IN_W:1];

    always_ff @(posedge clk) begin
        if (clr_all) begin
            rate_ff <= RST_BYTE;
        end else if (frame_done) begin
            rate_ff <= rate_rounded[REG_W-1:0];
        end
    end

    // ========================================================
    // firmware version, captured at end of boot
    // only the hardware reset clears it; a software reset keeps the version
    // (R5) capture version after boot
    always_ff @(posedge clk) begin
        if (rst) begin
            fw_ver_ff <= RST_BYTE;
        end else if (boot_done) begin
            fw_ver_ff <= fw_version_code;
        end
    end

    // ========================================================
    // run register
    // (R6) run bit written by host
    always_ff @(posedge clk) begin
        if (clr_all) begin
            run_ff <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_RUN) begin
            run_ff <= reg_wdata[RUN_BIT];
        end
    end

    // ========================================================
    // tone settings, byte writes; read-only offsets fall through
    // corner bytes land one at a time, so write both between two samples
    // (R16) only writable offsets decode
    always_ff @(posedge clk) begin
        if (clr_all) begin
            high_corner_ff <= RST_CORNER;
            low_corner_ff <= RST_CORNER;
            high_gain_ff <= RST_BYTE;
            low_gain_ff <= RST_BYTE;
            headroom_ff <= RST_BYTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                // (R8) treble corner byte pair
                OFS_HIGH_CORNER_LO: high_corner_ff[7:0] <= reg_wdata;
                OFS_HIGH_CORNER_HI: high_corner_ff[15:8] <= reg_wdata;
                // (R10) bass corner byte pair
                OFS_LOW_CORNER_LO: low_corner_ff[7:0] <= reg_wdata;
                OFS_LOW_CORNER_HI: low_corner_ff[15:8] <= reg_wdata;
                OFS_HIGH_SHELF_GAIN: high_gain_ff <= reg_wdata;
                OFS_LOW_SHELF_GAIN: low_gain_ff <= reg_wdata;
                OFS_TONE_HEADROOM: headroom_ff <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // gain limiting: out-of-range codes saturate at +-18 dB
    // readback stays raw so the host sees exactly the code it wrote
    // (R12) treble gain limit
    always_comb begin
        if ($signed(high_gain_ff) > GAIN_MAX_STEPS) begin
            high_gain_lim = GAIN_MAX_STEPS;
        end else if ($signed(high_gain_ff) < GAIN_MIN_STEPS) begin
            high_gain_lim = GAIN_MIN_STEPS;
        end else begin
            high_gain_lim = $signed(high_gain_ff);
        end
    end

    // (R13) bass gain limit
    always_comb begin
        if ($signed(low_gain_ff) > GAIN_MAX_STEPS) begin
            low_gain_lim = GAIN_MAX_STEPS;
        end else if ($signed(low_gain_ff) < GAIN_MIN_STEPS) begin
            low_gain_lim = GAIN_MIN_STEPS;
        end else begin
            low_gain_lim = $signed(low_gain_ff);
        end
    end

    // ========================================================
    // sample-aligned copies that the audio path really uses
    // the clamped gain is latched, so no out-of-range code reaches the filters
    // (R16) apply on next sample
    dstr_sample_latch #(.WIDTH(1)) u_run_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(run_ff),
        .applied(run_applied)
    );

    dstr_sample_latch #(.WIDTH(CORNER_W)) u_high_corner_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(high_corner_ff),
        .applied(treble_corner_hz)
    );

    dstr_sample_latch #(.WIDTH(CORNER_W)) u_low_corner_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(low_corner_ff),
        .applied(bass_corner_hz)
    );

    dstr_sample_latch #(.WIDTH(REG_W)) u_high_gain_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(high_gain_lim),
        .applied(high_gain_applied)
    );

    dstr_sample_latch #(.WIDTH(REG_W)) u_low_gain_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(low_gain_lim),
        .applied(low_gain_applied)
    );

    // (R14) headroom steps to output stage
    dstr_sample_latch #(.WIDTH(REG_W)) u_headroom_latch (
        .clk(clk),
        .rst(rst),
        .clear(sw_reset),
        .sample_tick(sample_tick),
        .src(headroom_ff),
        .applied(headroom_steps)
    );

    assign treble_gain_steps = $signed(high_gain_applied);
    assign bass_gain_steps = $signed(low_gain_applied);

    // ========================================================
    // decoder run state
    // clearing run returns to idle at the next sample, never mid-sample
    // (R6) leave idle on applied run
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DSTR_IDLE: begin
                if (run_applied) begin
                    nxt_state = DSTR_DECODE;
                end
            end
            DSTR_DECODE: begin
                if (!run_applied) begin
                    nxt_state = DSTR_IDLE;
                end
            end
            default: nxt_state = DSTR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (clr_all) begin
            state_ff <= DSTR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign decode_run = (state_ff == DSTR_DECODE);
    assign frame_count = frame_cnt_ff;

    // ========================================================
    // read path; unmapped offsets read as zero
    // count bytes are not snapshotted; a carry between byte reads can tear it
    // a read in the cycle of a write returns the value before the write
    // (R1) frame count byte mapping
    always_comb begin
        nxt_rdata = UNMAPPED_READ;
        unique case (reg_addr)
            OFS_FRAME_COUNT_LOW: nxt_rdata = frame_cnt_ff[7:0];
            OFS_FRAME_COUNT_MID: nxt_rdata = frame_cnt_ff[15:8];
            OFS_FRAME_COUNT_HIGH: nxt_rdata = frame_cnt_ff[23:16];
            OFS_MEAN_STREAM_RATE: nxt_rdata = rate_ff;
            OFS_FIRMWARE_VERSION: nxt_rdata = fw_ver_ff;
            OFS_RUN: nxt_rdata = {{(REG_W-1){1'b0}}, run_ff};
            OFS_HIGH_CORNER_LO: nxt_rdata = high_corner_ff[7:0];
            OFS_HIGH_CORNER_HI: nxt_rdata = high_corner_ff[15:8];
            OFS_LOW_CORNER_LO: nxt_rdata = low_corner_ff[7:0];
            OFS_LOW_CORNER_HI: nxt_rdata = low_corner_ff[15:8];
            OFS_HIGH_SHELF_GAIN: nxt_rdata = high_gain_ff;
            OFS_LOW_SHELF_GAIN: nxt_rdata = low_gain_ff;
            OFS_TONE_HEADROOM: nxt_rdata = headroom_ff;
            default: nxt_rdata = UNMAPPED_READ;
        endcase
    end

    // read data held until the next read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= RST_BYTE;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule : decoder_status_tone_regs

/* testbench/dstr_props.sv */
`timescale 1ns/100ps
// ========================================
// port-level checks for the status and tone registers
module dstr_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [dstr_pkg::REG_W-1:0] reg_rdata,
    input wire logic frame_done,
    input wire logic sample_tick,
    input wire logic decode_run,
    input wire logic [dstr_pkg::CORNER_W-1:0] treble_corner_hz,
    input wire logic signed [dstr_pkg::REG_W-1:0] treble_gain_steps,
    input wire logic signed [dstr_pkg::REG_W-1:0] bass_gain_steps,
    input wire logic [dstr_pkg::REG_W-1:0] headroom_steps,
    input wire logic [dstr_pkg::FRAME_CNT_W-1:0] frame_count
);
    import dstr_pkg::*;
    // both resets silence the checks unless a check is about reset itself
    default clocking @(posedge clk); endclocking
    default disable iff (rst || sw_reset);
    count_step_a: assert property (
        frame_done && !sw_reset |=> frame_count == $past(frame_count) + FRAME_CNT_ONE)
        else $error("frame count did not step by one");
    count_hold_a: assert property (!frame_done && !sw_reset |=> $stable(frame_count))
        else $error("frame count moved without a frame");
    hw_clear_a: assert property (disable iff (1'b0)
        rst |=> frame_count == RST_FRAME_CNT && !decode_run && headroom_steps == RST_BYTE)
        else $error("hardware reset left state behind");
    sw_clear_a: assert property (disable iff (rst)
        sw_reset |=> frame_count == RST_FRAME_CNT && !decode_run)
        else $error("software reset left state behind");
    gain_range_a: assert property (
        treble_gain_steps <= GAIN_MAX_STEPS && treble_gain_steps >= GAIN_MIN_STEPS
        && bass_gain_steps <= GAIN_MAX_STEPS && bass_gain_steps >= GAIN_MIN_STEPS)
        else $error("applied gain outside 18 dB");
    tone_hold_a: assert property (!sample_tick && !sw_reset |=> $stable(headroom_steps)
        && $stable(treble_corner_hz) && $stable(treble_gain_steps))
        else $error("tone setting changed off a sample");
    run_delay_a: assert property (
        $changed(decode_run) && !$past(rst) && !$past(sw_reset) |-> $past(sample_tick, 2))
        else $error("run state changed without a sample");
    cnt_read_a: assert property (
        reg_rd && reg_addr == OFS_FRAME_COUNT_MID |=> reg_rdata == $past(frame_count[15:8]))
        else $error("middle count byte read wrong");
    run_seen_c: cover property ($rose(decode_run));
    tick_seen_c: cover property (sample_tick ##1 headroom_steps != RST_BYTE);
    carry_seen_c: cover property (frame_done && frame_count[7:0] == 8'hFF);
endmodule : dstr_props

bind decoder_status_tone_regs dstr_props u_dstr_props (.clk, .rst, .sw_reset, .reg_addr,
    .reg_rd, .reg_rdata, .frame_done, .sample_tick, .decode_run, .treble_corner_hz,
    .treble_gain_steps, .bass_gain_steps, .headroom_steps, .frame_count);

/* testbench/dstr_host_model.sv */
`timescale 1ns/100ps
// ========================================
// control-bus master in place of the application controller
module dstr_host_model (
    input wire logic clk,
    input wire logic [dstr_pkg::REG_W-1:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [dstr_pkg::REG_W-1:0] reg_wdata,
    output logic reg_rd
);
    import dstr_pkg::*;
    // idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // one byte write; data inverted after the strobe so stale data never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // one byte read; data stands from the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : dstr_host_model

/* testbench/tb.sv */
`timescale 1ns/100ps
// ========================================
// self-checking bench for the status and tone registers
module tb;
    import dstr_pkg::*;
    // arbitrary version code
    localparam logic [7:0] FW_CODE = 8'h3C;
    logic clk, rst, sw_reset, frame_done, boot_done, sample_tick, reg_wr, reg_rd, decode_run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fw_version_code, headroom_steps, rb;
    logic [RATE_IN_W-1:0] avg_rate_kbps;
    logic [CORNER_W-1:0] treble_corner_hz, bass_corner_hz;
    logic signed [REG_W-1:0] treble_gain_steps, bass_gain_steps;
    logic [FRAME_CNT_W-1:0] frame_count;
    int n_mismatch = 0;
    int n_tests = 0;
    decoder_status_tone_regs u_decoder_status_tone_regs (.clk, .rst, .sw_reset, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .frame_done, .avg_rate_kbps, .boot_done,
        .fw_version_code, .sample_tick, .decode_run, .treble_corner_hz, .bass_corner_hz,
        .treble_gain_steps, .bass_gain_steps, .headroom_steps, .frame_count);
    dstr_host_model u_dstr_host_model (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd);
    // ========================================
    // helpers
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_dstr_host_model.wr(a, d);
    endtask : w
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        u_dstr_host_model.rd(a, rb);
        chk($sformatf("reg %h", a), {16'h0000, rb}, {16'h0000, exp});
    endtask : rchk
    // one sample; outputs and the delayed run state settle two edges on
    task automatic tick();
        @(posedge clk);
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        @(posedge clk);
        #1;
    endtask : tick
    // frame strobe held for n edges counts n frames
    task automatic frames(input int n, input logic [8:0] rate);
        @(posedge clk);
        frame_done <= 1'b1;
        avg_rate_kbps <= rate;
        repeat (n) @(posedge clk);
        frame_done <= 1'b0;
    endtask : frames
    // ========================================
    // scenarios
    task automatic t_reset();
        logic [7:0] ofs [14] = '{8'h67, 8'h68, 8'h69, 8'h6A, 8'h71, 8'h72, 8'h77, 8'h78,
            8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h50};
        foreach (ofs[i]) rchk(ofs[i], RST_BYTE);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_boot();
        @(posedge clk);
        boot_done <= 1'b1;
        fw_version_code <= FW_CODE;
        @(posedge clk);
        boot_done <= 1'b0;
        fw_version_code <= ~FW_CODE;
        w(OFS_FIRMWARE_VERSION, 8'h00);
        rchk(OFS_FIRMWARE_VERSION, FW_CODE);
        $display("t_boot done");
    endtask : t_boot
    task automatic t_status();
        frames(3, 9'h101);
        rchk(OFS_FRAME_COUNT_LOW, 8'h03);
        rchk(OFS_MEAN_STREAM_RATE, 8'h81);
        w(OFS_FRAME_COUNT_LOW, 8'hA5);
        w(OFS_MEAN_STREAM_RATE, 8'hA5);
        w(8'h50, 8'hFF);
        rchk(OFS_FRAME_COUNT_LOW, 8'h03);
        rchk(OFS_MEAN_STREAM_RATE, 8'h81);
        rchk(8'h50, UNMAPPED_READ);
        frames(255, 9'h12C);
        rchk(OFS_FRAME_COUNT_LOW, 8'h02);
        rchk(OFS_FRAME_COUNT_MID, 8'h01);
        rchk(OFS_FRAME_COUNT_HIGH, 8'h00);
        rchk(OFS_MEAN_STREAM_RATE, 8'h96);
        $display("t_status done");
    endtask : t_status
    task automatic t_tone();
        // headroom first, then corners with bass below treble
        w(OFS_TONE_HEADROOM, 8'h0C);
        w(OFS_HIGH_CORNER_LO, 8'hB8);
        w(OFS_HIGH_CORNER_HI, 8'h0B);
        w(OFS_LOW_CORNER_LO, 8'hC8);
        w(OFS_LOW_CORNER_HI, 8'h00);
        w(OFS_HIGH_SHELF_GAIN, 8'h0E);
        w(OFS_LOW_SHELF_GAIN, 8'hF0);
        rchk(OFS_HIGH_SHELF_GAIN, 8'h0E);
        chk("headroom early", 24'(headroom_steps), 24'h0);
        tick();
        chk("treble corner", 24'(treble_corner_hz), 24'h000BB8);
        chk("bass corner", 24'(bass_corner_hz), 24'h0000C8);
        chk("treble clamp", 24'(treble_gain_steps), 24'(GAIN_MAX_STEPS));
        chk("bass clamp", 24'(bass_gain_steps), 24'(GAIN_MIN_STEPS));
        chk("headroom", 24'(headroom_steps), 24'h00000C);
        w(OFS_HIGH_SHELF_GAIN, 8'hF5);
        w(OFS_LOW_SHELF_GAIN, 8'h0B);
        tick();
        chk("treble gain", 24'(treble_gain_steps), 24'hFFFFF5);
        chk("bass gain", 24'(bass_gain_steps), 24'h00000B);
        $display("t_tone done");
    endtask : t_tone
    task automatic t_run();
        // run is set only once every setting above is in place
        w(OFS_RUN, 8'h01);
        rchk(OFS_RUN, 8'h01);
        chk("run early", 24'(decode_run), 24'h0);
        tick();
        chk("run on", 24'(decode_run), 24'h1);
        w(OFS_RUN, 8'h00);
        tick();
        chk("run off", 24'(decode_run), 24'h0);
        w(OFS_RUN, 8'h01);
        tick();
        frames(2, 9'h101);
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        @(posedge clk);
        #1;
        chk("count after sw", 24'(frame_count), 24'h0);
        chk("run after sw", 24'(decode_run), 24'h0);
        rchk(OFS_RUN, RST_BYTE);
        rchk(OFS_TONE_HEADROOM, RST_BYTE);
        rchk(OFS_FIRMWARE_VERSION, FW_CODE);
        $display("t_run done");
    endtask : t_run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // ========================================
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // main sequence
    initial begin
        rst = 1'b1;
        sw_reset = 1'b0;
        frame_done = 1'b0;
        avg_rate_kbps = 9'h000;
        boot_done = 1'b0;
        fw_version_code = 8'h00;
        sample_tick = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_boot();
        t_status();
        t_tone();
        t_run();
        close_out();
    end
    // the whole run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule : tb
